/* hw/sbt_pkg.sv */
// constants shared by the sixteen-bit timer/counter and its helpers
package sbt_pkg;
	// register byte addresses on the axi4-lite slave
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_COUNT_LOW  = 8'h04;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;

	// control register field positions
	localparam int BIT_WIDE_ACCESS  = 7;
	localparam int BIT_SYSCLK_FLAG  = 6;
	localparam int BIT_PRESCALE_HI  = 5;
	localparam int BIT_PRESCALE_LO  = 4;
	localparam int BIT_LP_OSC_EN    = 3;
	localparam int BIT_SYNC_DISABLE = 2;
	localparam int BIT_SOURCE_SEL   = 1;
	localparam int BIT_RUN          = 0;

	// interrupt status, clear and enable share this layout
	localparam int BIT_OVERFLOW = 0;

	// values after reset, count limit and control write mask
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [15:0] COUNT_RESET     = 16'h0000;
	localparam logic [15:0] COUNT_MAX       = 16'hffff;
	localparam logic [7:0]  CTRL_WRITE_MASK = 8'hbf;

	// system clock cycles per instruction cycle (fosc/4)
	localparam int         INSTR_DIV   = 4;
	localparam int         INSTR_DIV_W = 2;
	localparam logic [1:0] INSTR_LAST  = 2'(INSTR_DIV - 1);

	// compare unit mode code that fires the special event trigger
	localparam logic [3:0] CMP_SPECIAL_EVENT = 4'hb;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hw/sbt_sync.sv */
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module sbt_sync #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} sbt_sync_state_t;

	sbt_sync_state_t s;
	sbt_sync_state_t next_s;

	generate
		if (W < 1) begin : g_bad_width
			$error("sync width must be at least one");
		end
	endgenerate

	// stage1 feeds stage2 only
	always_comb begin
		next_s        = s;
		next_s.stage1 = async_in;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.stage2;
endmodule // sbt_sync

/* hw/sbt_prescaler.sv */
// 1/2/4/8 prescaler for count ticks; its count is hidden from software
`timescale 1ns/1ps
module sbt_prescaler #(
	parameter int SEL_W = 2,
	parameter int CNT_W = 3
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// control
	input  wire logic [SEL_W-1:0] ratio_sel,
	input  wire logic             clear,
	// ticks
	input  wire logic             tick_in,
	output logic                  tick_out
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} sbt_presc_state_t;

	sbt_presc_state_t s;
	sbt_presc_state_t next_s;
	logic [CNT_W-1:0] mask;

	generate
		if (SEL_W < 1 || CNT_W < (1 << SEL_W) - 1) begin : g_bad_width
			$error("prescale counter too narrow for the ratio field");
		end
	endgenerate

	// ratio 2^sel: pass a tick when the low sel bits are all ones
	assign mask     = CNT_W'((1 << ratio_sel) - 1);
	assign tick_out = tick_in && ((s.cnt & mask) == mask);

	always_comb begin
		next_s = s;
		if (clear) begin
			next_s.cnt = '0;
		end else if (tick_in) begin
			next_s.cnt = tick_out ? '0 : s.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule // sbt_prescaler

/* hw/sbt_timer.sv */
// sixteen-bit timer/counter with axi4-lite registers and overflow interrupt
// Notes on behaviour
// - bit 7 chooses buffered 16-bit or byte access
// - bit 6 reads system-clock-from-oscillator status
// - bits 5-4 pick prescale 1, 2, 4, 8
// - bit 3 powers the low-power oscillator
// - bit 2 set marks counter mode asynchronous (no trigger reset); input still synchronised
// - bit 1 picks external edges or fosc/4
// - bit 0 runs counter; stopped counter holds
// - timer, synchronous and asynchronous counter modes exist
// - oscillator on disables its two pins' digital logic
// - internal source counts every n instruction cycles
// - falling edge needed before first counted rise
// - wrap from ffff sets overflow flag, enable gates
// - in 16-bit mode, low read buffers high; low write loads both
// - count writes clear prescaler, per access mode
// - compare special event resets count unless asynchronous
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module sbt_timer #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// count sources
	input  wire logic              ext_count_input,
	input  wire logic              lp_osc_clk,
	output logic                   lp_osc_enable,
	// system clock selection status
	input  wire logic              sysclk_from_lp_osc_flag,
	// compare unit special event trigger
	input  wire logic              special_event_trigger,
	input  wire logic [3:0]        compare_mode_code,
	// oscillator pins as port bits 1:0 (direction 1 = input)
	input  wire logic [1:0]        port_c_direction,
	input  wire logic [1:0]        port_c_out_data,
	input  wire logic [1:0]        osc_pin_in,
	output logic [1:0]             osc_pin_out,
	output logic [1:0]             osc_pin_oe,
	output logic [1:0]             osc_pin_read,
	// interrupt
	output logic                   irq
);
	localparam int INSTR_DIV_W_L = sbt_pkg::INSTR_DIV_W;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              aw_held;
		logic [7:0]        wbyte;
		logic              wbyte_en;
		logic              w_held;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [7:0]        ctrl;
		logic [15:0]       count;
		logic [7:0]        high_buf;
		logic              overflow_flag;
		logic              overflow_irq_enable;
		logic              armed;
		logic              src_prev;
		logic [INSTR_DIV_W_L-1:0] div;
		logic [1:0]        pin_out;
		logic [1:0]        pin_oe;
		logic [1:0]        pin_read;
		logic              irq;
	} sbt_state_t;

	sbt_state_t s;
	sbt_state_t next_s;

	generate
		if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
			$error("address width must be 8 to 32 bits");
		end
		// the free-running divider wraps at a power of two
		if (sbt_pkg::INSTR_DIV != (1 << sbt_pkg::INSTR_DIV_W)) begin : g_bad_div
			$error("instruction divider width does not match its ratio");
		end
		if (sbt_pkg::CTRL_WRITE_MASK[sbt_pkg::BIT_SYSCLK_FLAG] != 1'b0) begin : g_bad_mask
			$error("control write mask must exclude the status bit");
		end
	endgenerate

	// registers sit in the low 8 address bits; upper bits must be zero
	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] lo;
		lo = a[7:0];
		return ((a >> 8) == '0) && (
			lo == sbt_pkg::ADDR_CTRL || lo == sbt_pkg::ADDR_COUNT_LOW ||
			lo == sbt_pkg::ADDR_COUNT_HIGH || lo == sbt_pkg::ADDR_IRQ_STATUS ||
			lo == sbt_pkg::ADDR_IRQ_CLEAR || lo == sbt_pkg::ADDR_IRQ_ENABLE);
	endfunction

	function automatic logic reg_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		return reg_mapped(a) && (a[7:0] == off);
	endfunction

	// synchronised pins: {pin1, pin0, oscillator, external input}
	logic [3:0] pins_sync;

	sbt_sync #(
		.W (4)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({osc_pin_in, lp_osc_clk, ext_count_input}),
		.sync_out (pins_sync)
	);

	// control fields
	logic       wide_access_select;
	logic [1:0] count_prescale_sel;
	logic       ext_sync_disable;
	logic       count_source_sel;
	logic       counter_run;

	assign wide_access_select = s.ctrl[sbt_pkg::BIT_WIDE_ACCESS];
	assign count_prescale_sel = s.ctrl[sbt_pkg::BIT_PRESCALE_HI:sbt_pkg::BIT_PRESCALE_LO];
	assign lp_osc_enable      = s.ctrl[sbt_pkg::BIT_LP_OSC_EN];
	assign ext_sync_disable   = s.ctrl[sbt_pkg::BIT_SYNC_DISABLE];
	assign count_source_sel   = s.ctrl[sbt_pkg::BIT_SOURCE_SEL];
	assign counter_run        = s.ctrl[sbt_pkg::BIT_RUN];

	// bus strobes
	logic do_write;
	logic do_read;
	logic wr_mapped;
	logic wr_ctrl;
	logic wr_low;
	logic wr_high;
	logic wr_clear;
	logic wr_enable;
	logic count_write;
	logic presc_clear;

	assign s_axi_awready = !s.aw_held;
	assign s_axi_wready  = !s.w_held;
	assign s_axi_arready = !s.rvalid;
	assign do_write      = s.aw_held && s.w_held && !s.bvalid;
	assign do_read       = s_axi_arvalid && !s.rvalid;
	assign wr_mapped     = do_write && reg_mapped(s.awaddr);
	assign wr_ctrl       = do_write && s.wbyte_en && reg_is(s.awaddr, sbt_pkg::ADDR_CTRL);
	assign wr_low        = do_write && s.wbyte_en && reg_is(s.awaddr, sbt_pkg::ADDR_COUNT_LOW);
	assign wr_high       = do_write && s.wbyte_en && reg_is(s.awaddr, sbt_pkg::ADDR_COUNT_HIGH);
	assign wr_clear      = do_write && s.wbyte_en && reg_is(s.awaddr, sbt_pkg::ADDR_IRQ_CLEAR);
	assign wr_enable     = do_write && s.wbyte_en && reg_is(s.awaddr, sbt_pkg::ADDR_IRQ_ENABLE);
	assign count_write   = wr_low || wr_high;
	// in wide mode a high-byte write fills the buffer and drops the arm, but keeps the prescaler
	assign presc_clear   = wr_low || (wr_high && !wide_access_select);

	// count source: oscillator output replaces the pin while enabled
	logic src_level;
	logic src_rise;
	logic src_fall;
	logic ext_tick;
	logic int_tick;
	logic presc_tick;

	assign src_level = lp_osc_enable ? pins_sync[1] : pins_sync[0];
	assign src_rise  = src_level && !s.src_prev;
	assign src_fall  = !src_level && s.src_prev;
	// rising edges count only once a falling edge has been seen
	assign ext_tick  = counter_run && count_source_sel && src_rise && s.armed;
	assign int_tick  = counter_run && !count_source_sel && (s.div == sbt_pkg::INSTR_LAST);

	logic count_tick;
	assign count_tick = ext_tick || int_tick;

	sbt_prescaler #(
		.SEL_W (2),
		.CNT_W (3)
	) u_presc (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ratio_sel (count_prescale_sel),
		.clear     (presc_clear),
		.tick_in   (count_tick),
		.tick_out  (presc_tick)
	);

	// operating modes; the asynchronous one still samples through the synchroniser,
	// so with one clock an external level must last over one aclk period to count
	logic mode_timer;
	logic mode_sync_count;
	assign mode_timer      = !count_source_sel;
	assign mode_sync_count = count_source_sel && !ext_sync_disable;

	// trigger is honoured only in timer or synchronised counter mode
	logic trig_reset;
	assign trig_reset = special_event_trigger &&
		(compare_mode_code == sbt_pkg::CMP_SPECIAL_EVENT) &&
		(mode_timer || mode_sync_count);

	logic [7:0] ctrl_view;
	// status bit comes only from the clock selection logic
	always_comb begin
		ctrl_view = s.ctrl;
		ctrl_view[sbt_pkg::BIT_SYSCLK_FLAG] = sysclk_from_lp_osc_flag;
	end

	always_comb begin
		next_s = s;

		// write channels are taken independently, in either order
		if (s_axi_awvalid && !s.aw_held) begin
			next_s.awaddr  = s_axi_awaddr;
			next_s.aw_held = 1'b1;
		end
		if (s_axi_wvalid && !s.w_held) begin
			next_s.wbyte    = s_axi_wdata[7:0];
			next_s.wbyte_en = s_axi_wstrb[0];
			next_s.w_held   = 1'b1;
		end
		if (do_write) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = wr_mapped ? sbt_pkg::RESP_OKAY : sbt_pkg::RESP_SLVERR;
		end else if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end

		// read: one cycle to rvalid, held until rready
		if (do_read) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = reg_mapped(s_axi_araddr) ? sbt_pkg::RESP_OKAY : sbt_pkg::RESP_SLVERR;
			next_s.rdata  = 32'h0;
			if (reg_is(s_axi_araddr, sbt_pkg::ADDR_CTRL)) begin
				next_s.rdata[7:0] = ctrl_view;
			end else if (reg_is(s_axi_araddr, sbt_pkg::ADDR_COUNT_LOW)) begin
				next_s.rdata[7:0] = s.count[7:0];
				if (wide_access_select) begin
					next_s.high_buf = s.count[15:8];
				end
			end else if (reg_is(s_axi_araddr, sbt_pkg::ADDR_COUNT_HIGH)) begin
				next_s.rdata[7:0] = wide_access_select ? s.high_buf : s.count[15:8];
			end else if (reg_is(s_axi_araddr, sbt_pkg::ADDR_IRQ_STATUS)) begin
				next_s.rdata[sbt_pkg::BIT_OVERFLOW] = s.overflow_flag;
			end else if (reg_is(s_axi_araddr, sbt_pkg::ADDR_IRQ_ENABLE)) begin
				next_s.rdata[sbt_pkg::BIT_OVERFLOW] = s.overflow_irq_enable;
			end
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end

		if (wr_ctrl) begin
			next_s.ctrl = s.wbyte & sbt_pkg::CTRL_WRITE_MASK;
		end
		if (wr_enable) begin
			next_s.overflow_irq_enable = s.wbyte[sbt_pkg::BIT_OVERFLOW];
		end

		// instruction-cycle divider runs free
		next_s.div = (s.div == sbt_pkg::INSTR_LAST) ? '0 : s.div + INSTR_DIV_W_L'(1);

		// edge history and arming
		// stopping drops the arm, so a restart with the pin low still waits for a fall
		next_s.src_prev = src_level;
		if (count_write || !counter_run) begin
			next_s.armed = 1'b0;
		end else if (src_fall) begin
			next_s.armed = 1'b1;
		end

		// count: write beats trigger beats increment; stopped counter holds
		if (wr_low) begin
			next_s.count = wide_access_select ? {s.high_buf, s.wbyte}
				: {s.count[15:8], s.wbyte};
		end else if (wr_high) begin
			if (wide_access_select) begin
				next_s.high_buf = s.wbyte;
			end else begin
				next_s.count[15:8] = s.wbyte;
			end
		end else if (trig_reset) begin
			next_s.count = sbt_pkg::COUNT_RESET;
		end else if (presc_tick) begin
			next_s.count = s.count + 16'h0001;
		end

		// overflow flag: hardware set wins over software clear
		if (wr_clear && s.wbyte[sbt_pkg::BIT_OVERFLOW]) begin
			next_s.overflow_flag = 1'b0;
		end
		if (presc_tick && !count_write && !trig_reset && s.count == sbt_pkg::COUNT_MAX) begin
			next_s.overflow_flag = 1'b1;
		end
		next_s.irq = next_s.overflow_flag && next_s.overflow_irq_enable;

		// oscillator owns its pins: no drive, reads as zero
		next_s.pin_out  = port_c_out_data;
		next_s.pin_oe   = lp_osc_enable ? 2'h0 : ~port_c_direction;
		next_s.pin_read = lp_osc_enable ? 2'h0 : pins_sync[3:2];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s      <= '0;
			s.ctrl <= sbt_pkg::CTRL_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp  = s.bresp;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata  = s.rdata;
	assign s_axi_rresp  = s.rresp;
	assign osc_pin_out  = s.pin_out;
	assign osc_pin_oe   = s.pin_oe;
	assign osc_pin_read = s.pin_read;
	assign irq          = s.irq;
endmodule // sbt_timer

/* sim/sbt_timer_monitor.sv */
// checker for bus answers, oscillator pin gating and interrupt release
`timescale 1ns/1ps
module sbt_timer_monitor (
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// bus handshakes
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	// oscillator, pins, interrupt
	input wire logic       lp_osc_enable,
	input wire logic [1:0] port_c_direction,
	input wire logic [1:0] osc_pin_oe,
	input wire logic [1:0] osc_pin_read,
	input wire logic       irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read data late");
	property p_ar_gate; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_gate: assert property (p_ar_gate)
		else $error("read address taken while data pending");
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
		|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write response late");
	property p_osc_oe; lp_osc_enable && $past(lp_osc_enable) |-> osc_pin_oe == 2'b00; endproperty
	a_osc_oe: assert property (p_osc_oe)
		else $error("pin driven while oscillator on");
	property p_osc_rd; lp_osc_enable && $past(lp_osc_enable) |-> osc_pin_read == 2'b00; endproperty
	a_osc_rd: assert property (p_osc_rd)
		else $error("pin read nonzero while oscillator on");
	// two quiet cycles so a registered enable has settled
	property p_oe_dir;
		!lp_osc_enable && !$past(lp_osc_enable) && $past(aresetn)
		|-> osc_pin_oe == ~$past(port_c_direction);
	endproperty
	a_oe_dir: assert property (p_oe_dir)
		else $error("pin drive does not follow direction");
	property p_osc_src; $changed(lp_osc_enable) |-> !$past(s_axi_wready); endproperty
	a_osc_src: assert property (p_osc_src)
		else $error("oscillator enable moved without a write");
	property p_irq_fall; $fell(irq) |-> !$past(s_axi_wready) || !$past(s_axi_wready, 2); endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt dropped without a write");
endmodule // sbt_timer_monitor

bind sbt_timer sbt_timer_monitor u_mon (.*);

/* sim/sbt_ext_src.sv */
// stand-in for the external count pin and the low-power oscillator
`timescale 1ns/1ps
module sbt_ext_src (
	// clock
	input wire logic aclk,
	// count lines
	output logic     ext_count_input,
	output logic     lp_osc_clk
);
	initial begin
		ext_count_input = 1'b0;
		lp_osc_clk = 1'b0;
	end
	// n rising edges, each level held hw cycles; always ends low so a fall precedes
	task automatic edges(input bit osc, input int n, input int hw);
		for (int i = 0; i < 2 * n; i++) begin
			repeat (hw) @(posedge aclk);
			if (osc)
				lp_osc_clk <= ~lp_osc_clk;
			else
				ext_count_input <= ~ext_count_input;
		end
	endtask
endmodule // sbt_ext_src

/* sim/sbt_timer_tb.sv */
// self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ps
module sbt_timer_tb;
	localparam logic [7:0] a_ct = sbt_pkg::ADDR_CTRL;
	localparam logic [7:0] a_lo = sbt_pkg::ADDR_COUNT_LOW;
	localparam logic [7:0] a_hi = sbt_pkg::ADDR_COUNT_HIGH;
	logic        aclk, aresetn, irq, ext_count_input, lp_osc_clk, lp_osc_enable;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
	logic [3:0]  s_axi_wstrb, compare_mode_code;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, port_c_direction, port_c_out_data;
	logic [1:0]  osc_pin_in, osc_pin_out, osc_pin_oe, osc_pin_read;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        sysclk_from_lp_osc_flag, special_event_trigger;
	int          err_total, n_checks;

	sbt_timer u_dut (.*);
	sbt_ext_src u_src (.aclk(aclk), .ext_count_input(ext_count_input), .lp_osc_clk(lp_osc_clk));

	always #25 aclk = ~aclk;

	task automatic tally_and_finish();
		if (err_total == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// handshakes resolve at the sampled edge; a stuck bus ends the run
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int t;
		t = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && t < 50);
		// bready stays up so a back-to-back call never drops and raises it at one edge
		chk("bresp", s_axi_bresp, sbt_pkg::RESP_OKAY);
		if (!s_axi_bvalid) begin
			err_total++;
			tally_and_finish();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		int t;
		t = 0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && t < 50);
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
		if (!s_axi_rvalid) begin
			err_total++;
			tally_and_finish();
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
		rd(a);
		chk(nm, rdv, {24'h0, e});
		chk("rresp", rsp, sbt_pkg::RESP_OKAY);
	endtask
	task automatic fire(input logic [3:0] m);
		compare_mode_code <= m;
		special_event_trigger <= 1'b1;
		tick(1);
		special_event_trigger <= 1'b0;
		tick(1);
	endtask

	task automatic t_reg();
		rc(a_ct, 8'h00, "ctl rst");
		rc(sbt_pkg::ADDR_IRQ_ENABLE, 8'h00, "ien rst");
		sysclk_from_lp_osc_flag <= 1'b1;
		wr(a_ct, 8'h80);
		rc(a_ct, 8'hc0, "ctl flag");
		sysclk_from_lp_osc_flag <= 1'b0;
		wr(a_ct, 8'h70);
		rc(a_ct, 8'h30, "ctl ro");
		rd(8'h20);
		chk("unmapped rresp", rsp, sbt_pkg::RESP_SLVERR);
		chk("unmapped rdata", rdv, 32'h0);
	endtask
	task automatic t_presc();
		for (int ps = 0; ps < 4; ps++) begin
			wr(a_ct, 8'h00);
			wr(a_lo, 8'h00);
			wr(a_hi, 8'h00);
			wr(a_ct, {2'b00, 2'(ps), 4'h1});
			tick(32 << ps);
			wr(a_ct, 8'h00);
			rd(a_lo);
			chk("prescaled", 32'(rdv >= 7 && rdv <= 9), 32'h1);
			tick(20);
			rc(a_lo, rdv[7:0], "held");
		end
	endtask
	task automatic t_ovf();
		wr(a_hi, 8'hff);
		wr(a_lo, 8'hf8);
		wr(sbt_pkg::ADDR_IRQ_ENABLE, 8'h01);
		wr(a_ct, 8'h01);
		tick(60);
		chk("irq wrap", irq, 1'b1);
		rc(sbt_pkg::ADDR_IRQ_STATUS, 8'h01, "sts");
		wr(sbt_pkg::ADDR_IRQ_ENABLE, 8'h00);
		tick(2);
		chk("irq mask", irq, 1'b0);
		wr(sbt_pkg::ADDR_IRQ_ENABLE, 8'h01);
		tick(2);
		chk("irq unmask", irq, 1'b1);
		wr(sbt_pkg::ADDR_IRQ_CLEAR, 8'h01);
		tick(2);
		chk("irq clr", irq, 1'b0);
		wr(a_ct, 8'h00);
		rc(a_hi, 8'h00, "hi wrap");
	endtask
	task automatic t_wide();
		wr(a_ct, 8'h80);
		wr(a_hi, 8'h12);
		wr(a_lo, 8'h34);
		rc(a_lo, 8'h34, "lo16");
		rc(a_hi, 8'h12, "hi16");
		wr(a_hi, 8'h77);
		wr(a_ct, 8'h00);
		rc(a_hi, 8'h12, "hi buf only");
		wr(a_hi, 8'h56);
		rc(a_hi, 8'h56, "hi8");
		rc(a_lo, 8'h34, "lo8");
	endtask
	task automatic t_ext();
		wr(a_lo, 8'h00);
		wr(a_hi, 8'h00);
		wr(a_ct, 8'h03);
		u_src.edges(1'b0, 5, 4);
		tick(8);
		rc(a_lo, 8'h04, "sync ext");
		wr(a_ct, 8'h07);
		u_src.edges(1'b0, 3, 4);
		tick(8);
		rc(a_lo, 8'h07, "async ext");
		wr(a_lo, 8'h00);
		wr(a_ct, 8'h0f);
		osc_pin_in <= 2'b11;
		u_src.edges(1'b1, 3, 4);
		u_src.edges(1'b0, 2, 4);
		tick(8);
		rc(a_lo, 8'h02, "osc count");
		chk("osc on", {lp_osc_enable, osc_pin_read, osc_pin_oe}, 5'h10);
		wr(a_ct, 8'h00);
		tick(4);
		chk("osc off", {lp_osc_enable, osc_pin_read, osc_pin_oe}, 5'h0f);
		port_c_direction <= 2'b01;
		port_c_out_data <= 2'b10;
		tick(2);
		chk("pin drive", {osc_pin_oe, osc_pin_out}, 4'ha);
	endtask
	task automatic t_trig();
		wr(a_ct, 8'h03);
		wr(a_lo, 8'h50);
		fire(sbt_pkg::CMP_SPECIAL_EVENT ^ 4'h1);
		rc(a_lo, 8'h50, "other mode");
		fire(sbt_pkg::CMP_SPECIAL_EVENT);
		rc(a_lo, 8'h00, "trig");
		wr(a_lo, 8'h50);
		wr(a_ct, 8'h07);
		fire(sbt_pkg::CMP_SPECIAL_EVENT);
		rc(a_lo, 8'h50, "async trig");
	endtask

	initial begin
		{aclk, aresetn, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, sysclk_from_lp_osc_flag, special_event_trigger} = '0;
		{compare_mode_code, port_c_direction, port_c_out_data, osc_pin_in} = '0;
		{err_total, n_checks} = '0;
		s_axi_wstrb = 4'h1;
		tick(8);
		aresetn <= 1'b1;
		t_reg();
		t_presc();
		t_ovf();
		t_wide();
		t_ext();
		t_trig();
		tally_and_finish();
	end
endmodule // sbt_timer_tb
